// ===== src/pwmsd_top.sv
// PWM auto-shutdown and output polarity logic with register port
// Function
// - Mode field low bits set pair polarity
// - Period flag set as second period begins
// - All pins high impedance after reset
// - Source field selects comparators and pin
// - Firmware setting status bit is shutdown event
// - Status bit shows shutdown state
// - Status sticks until firmware or auto-restart
// - Shutdown forces enabled pins asynchronously, except comparator two when its sync enable holds it to the timer tick
// - Pair fields choose drive 0, 1, tri-state
// - Status writes ignored while condition present
// - Outputs resume at next period start
// - Auto-restart clears status when condition gone
`timescale 1ns/100ps
`default_nettype none

module pwmsd_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    input wire logic [3:0] pwm_raw_in,
    input wire logic period_start_in,
    input wire logic cmp_one_in,
    input wire logic cmp_two_in,
    input wire logic ext_int_n_in,
    input wire logic sync_tick_in,
    output logic [3:0] pwm_pin_out,
    output logic [3:0] pwm_pin_oe_out,
    output logic irq_out
);

    // ==========================================================
    // Source decode
    function automatic logic src_hit(input logic [2:0] src, input logic c1,
                                     input logic c2, input logic pin_low);
        src_hit = (src[0] & c1) | (src[1] & c2) | (src[2] & pin_low);
    endfunction

    pwmsd_pkg::pwmsd_sdctl_type sdctl_ff;
    pwmsd_pkg::pwmsd_sdctl_type nxt_sdctl;
    pwmsd_pkg::pwmsd_irq_type irq_stat_ff;
    pwmsd_pkg::pwmsd_irq_type nxt_irq_stat;
    pwmsd_pkg::pwmsd_irq_type irq_mask_ff;
    logic [3:0] mode_ff;
    logic run_ff;
    logic [7:0] cfg_ff;
    logic [3:0] drive_ff;
    logic [7:0] rd_data_ff;
    logic irq_ff;
    logic hold_ff;
    logic seen_ff;
    logic cmp2_held_ff;
    logic [3:0] pin_lvl_ff;
    logic [2:0] trig_sync;
    logic c1_s;
    logic c2_s;
    logic int_low_s;

    // ==========================================================
    // Address decode
    wire wr_sd = wr_en_in && (addr_in == pwmsd_pkg::ADDR_SDCTL);
    wire wr_mod = wr_en_in && (addr_in == pwmsd_pkg::ADDR_MODCTL);
    wire wr_cfg = wr_en_in && (addr_in == pwmsd_pkg::ADDR_CFG);
    wire wr_drv = wr_en_in && (addr_in == pwmsd_pkg::ADDR_DRIVE);
    wire wr_ist = wr_en_in && (addr_in == pwmsd_pkg::ADDR_IRQ_STAT);
    wire wr_msk = wr_en_in && (addr_in == pwmsd_pkg::ADDR_IRQ_MASK);
    wire restart_en = cfg_ff[pwmsd_pkg::CFG_RESTART_BIT];
    wire comparator_two_sync_enable_en = cfg_ff[pwmsd_pkg::CFG_COMPARATOR_TWO_SYNC_ENABLE_BIT];
    wire pol_ac = mode_ff[pwmsd_pkg::MOD_POL_AC_BIT];
    wire pol_bd = mode_ff[pwmsd_pkg::MOD_POL_BD_BIT];

    // ==========================================================
    // Trigger conditions
    // two-flop trigger sync
    pwmsd_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({cmp_one_in, cmp_two_in, ~ext_int_n_in}),
        .sync_out(trig_sync)
    );
    assign c1_s = trig_sync[2];
    assign c2_s = trig_sync[1];
    assign int_low_s = trig_sync[0];

    wire c2_async = comparator_two_sync_enable_en ? cmp2_held_ff : cmp_two_in;
    wire c2_eff_s = comparator_two_sync_enable_en ? cmp2_held_ff : c2_s;
    wire cond_raw = src_hit(sdctl_ff.src, cmp_one_in, c2_async, ~ext_int_n_in);
    wire cond_s = src_hit(sdctl_ff.src, c1_s, c2_eff_s, int_low_s);
    wire fw_set = wr_sd && wr_data_in[7];
    wire set_evt = cond_s || fw_set;
    wire shutdown_w = cond_raw || sdctl_ff.status || hold_ff;

    // ==========================================================
    // Status bit and register next values
    always_comb begin
        nxt_sdctl = sdctl_ff;
        if (wr_sd) begin
            nxt_sdctl = pwmsd_sdctl_type_from(wr_data_in, sdctl_ff.status);
        end
        if (!cond_s && ((wr_sd && !wr_data_in[7]) || restart_en)) begin
            nxt_sdctl.status = 1'b0;
        end
        if (set_evt) begin
            nxt_sdctl.status = 1'b1;
        end
    end

    function automatic pwmsd_pkg::pwmsd_sdctl_type pwmsd_sdctl_type_from(
        input logic [7:0] d, input logic st);
        pwmsd_sdctl_type_from = pwmsd_pkg::pwmsd_sdctl_type'({st, d[6:0]});
    endfunction

    wire period_evt = period_start_in && run_ff && seen_ff;
    wire sd_rise = set_evt && !sdctl_ff.status;

    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_ist) begin
            nxt_irq_stat = irq_stat_ff & ~pwmsd_pkg::pwmsd_irq_type'(wr_data_in[1:0]);
        end
        // flag from the second period start on
        if (period_evt) begin
            nxt_irq_stat.period = 1'b1;
        end
        if (sd_rise) begin
            nxt_irq_stat.shutdown = 1'b1;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sdctl_ff <= pwmsd_pkg::pwmsd_sdctl_type'(pwmsd_pkg::SDCTL_RST);
            irq_stat_ff <= pwmsd_pkg::pwmsd_irq_type'(pwmsd_pkg::IRQ_RST);
            irq_mask_ff <= pwmsd_pkg::pwmsd_irq_type'(pwmsd_pkg::IRQ_RST);
            mode_ff <= pwmsd_pkg::MODE_RST;
            run_ff <= pwmsd_pkg::RUN_RST;
            cfg_ff <= pwmsd_pkg::CFG_RST;
            drive_ff <= pwmsd_pkg::DRIVE_RST;
        end else begin
            sdctl_ff <= nxt_sdctl;
            irq_stat_ff <= nxt_irq_stat;
            if (wr_msk) begin
                irq_mask_ff <= pwmsd_pkg::pwmsd_irq_type'(wr_data_in[1:0]);
            end
            if (wr_mod) begin
                mode_ff <= wr_data_in[3:0];
                run_ff <= wr_data_in[pwmsd_pkg::MOD_RUN_BIT];
            end
            if (wr_cfg) begin
                cfg_ff <= wr_data_in;
            end
            if (wr_drv) begin
                drive_ff <= wr_data_in[3:0];
            end
        end
    end

    // ==========================================================
    // Period tracking, restart hold and comparator sampling
    wire nxt_seen = run_ff && (seen_ff || period_start_in);
    wire nxt_hold = sdctl_ff.status || cond_s || (hold_ff && !period_start_in);
    wire nxt_cmp2_held = sync_tick_in ? c2_s : cmp2_held_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_ff <= 1'b0;
            hold_ff <= 1'b0;
            cmp2_held_ff <= 1'b0;
        end else begin
            seen_ff <= nxt_seen;
            hold_ff <= nxt_hold;
            cmp2_held_ff <= nxt_cmp2_held;
        end
    end

    // ==========================================================
    // Pin levels and shutdown states
    // pair polarity applied to raw waveform
    wire [3:0] nxt_pin_lvl = pwm_raw_in ^ {pol_bd, pol_ac, pol_bd, pol_ac};
    wire [1:0] pair_pss [pwmsd_pkg::NUM_PINS];
    assign pair_pss[0] = sdctl_ff.pss_ac;
    assign pair_pss[1] = sdctl_ff.pss_bd;
    assign pair_pss[2] = sdctl_ff.pss_ac;
    assign pair_pss[3] = sdctl_ff.pss_bd;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_lvl_ff <= 4'h0;
        end else begin
            pin_lvl_ff <= nxt_pin_lvl;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < pwmsd_pkg::NUM_PINS; gi++) begin : g_pin
            assign pwm_pin_out[gi] = shutdown_w ? pair_pss[gi][0] : pin_lvl_ff[gi];
            assign pwm_pin_oe_out[gi] = drive_ff[gi] && !(shutdown_w && pair_pss[gi][1]);
        end
    endgenerate

    // ==========================================================
    // Read port and interrupt
    // status bit read back
    wire [7:0] rd_mux =
        (addr_in == pwmsd_pkg::ADDR_SDCTL) ? sdctl_ff :
        (addr_in == pwmsd_pkg::ADDR_MODCTL) ? {run_ff, 3'h0, mode_ff} :
        (addr_in == pwmsd_pkg::ADDR_CFG) ? cfg_ff :
        (addr_in == pwmsd_pkg::ADDR_DRIVE) ? {4'h0, drive_ff} :
        (addr_in == pwmsd_pkg::ADDR_IRQ_STAT) ? {6'h00, irq_stat_ff} :
        (addr_in == pwmsd_pkg::ADDR_IRQ_MASK) ? {6'h00, irq_mask_ff} : 8'h00;
    wire nxt_irq = |(nxt_irq_stat & irq_mask_ff);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else begin
            rd_data_ff <= rd_en_in ? rd_mux : 8'h00;
            irq_ff <= nxt_irq;
        end
    end

    assign rd_data_out = rd_data_ff;
    assign irq_out = irq_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_status_sets: assert property (cond_s |=> sdctl_ff.status)
        else $error("status not set by condition");
    chk_fw_event: assert property (fw_set |=> sdctl_ff.status && shutdown_w)
        else $error("firmware set not a shutdown event");
    chk_clear_ignored: assert property (
        (wr_sd && !wr_data_in[7] && cond_s) |=> sdctl_ff.status)
        else $error("status cleared while condition present");
    chk_auto_restart: assert property (
        (sdctl_ff.status && restart_en && !set_evt) |=> !sdctl_ff.status)
        else $error("auto-restart did not clear status");
    chk_resume_wait: assert property (
        (hold_ff && !period_start_in) |=> hold_ff && shutdown_w)
        else $error("outputs resumed before period start");
    chk_force_level: assert property (
        (shutdown_w && !sdctl_ff.pss_ac[1]) |-> pwm_pin_out[0] == sdctl_ff.pss_ac[0])
        else $error("pair A/C not forced to shutdown level");
    chk_pair_tristate: assert property (
        (shutdown_w && sdctl_ff.pss_bd[1]) |-> !pwm_pin_oe_out[1] && !pwm_pin_oe_out[3])
        else $error("pair B/D not tri-stated");
    chk_drive_off: assert property ((drive_ff == 4'h0) |-> pwm_pin_oe_out == 4'h0)
        else $error("pin driven without enable");
    chk_polarity: assert property (
        !shutdown_w |-> pwm_pin_out[1] == ($past(pwm_raw_in[1]) ^ $past(pol_bd)))
        else $error("pair B/D polarity wrong");
    chk_period_flag: assert property (
        (period_start_in && run_ff && !seen_ff) |=> !$rose(irq_stat_ff.period))
        else $error("period flag set on first period start");
    chk_source_off: assert property (
        (sdctl_ff.src == pwmsd_pkg::SRC_OFF) |-> !cond_raw && !cond_s)
        else $error("shutdown condition with sources disabled");
    chk_c2_held: assert property (
        (comparator_two_sync_enable_en && !sync_tick_in) |=> $stable(cmp2_held_ff))
        else $error("comparator two changed between timer ticks");
    chk_sync_path: assert property (
        (sdctl_ff.src == 3'h4 && !int_low_s) |=> ##1 (sdctl_ff.src != 3'h4
            || !$past(~ext_int_n_in, 2) || cond_s))
        else $error("pin trigger not seen two cycles later");

    cov_shutdown: cover property (sd_rise ##[1:20] !sdctl_ff.status);
    cov_restart: cover property (restart_en && $fell(sdctl_ff.status) ##[1:50] !hold_ff);
    cov_period: cover property ($rose(irq_stat_ff.period));
    cov_tristate: cover property (shutdown_w && drive_ff[0] && !pwm_pin_oe_out[0]);

endmodule
`default_nettype wire

// ===== src/pwmsd_pkg.sv
// Package: register map, field layout and types for the PWM shutdown block
package pwmsd_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_SDCTL = 8'h00;
    localparam logic [7:0] ADDR_MODCTL = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam logic [7:0] ADDR_DRIVE = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // ==========================================================
    // Field positions
    localparam int MOD_RUN_BIT = 7;
    localparam int MOD_POL_AC_BIT = 1;
    localparam int MOD_POL_BD_BIT = 0;
    localparam int CFG_RESTART_BIT = 7;
    localparam int CFG_COMPARATOR_TWO_SYNC_ENABLE_BIT = 0;
    localparam int IRQ_PERIOD_BIT = 0;
    localparam int IRQ_SHUTDOWN_BIT = 1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SDCTL_RST = 8'h00;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic RUN_RST = 1'b0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [3:0] DRIVE_RST = 4'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // ==========================================================
    // Encodings and sizes
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam int SYNC_STAGES = 2;
    localparam int NUM_PINS = 4;

    typedef struct packed {
        logic status;
        logic [2:0] src;
        logic [1:0] pss_ac;
        logic [1:0] pss_bd;
    } pwmsd_sdctl_type;

    typedef struct packed {
        logic shutdown;
        logic period;
    } pwmsd_irq_type;

endpackage

// ===== src/pwmsd_sync.sv
// Two-stage synchroniser for asynchronous trigger levels
`timescale 1ns/100ps
`default_nettype none

module pwmsd_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ==========================================================
    // Stages
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule
`default_nettype wire

// ===== tb/pwmsd_load.sv
// Model of the external switch drivers with pull-down resistors on the pins
`timescale 1ns/100ps
`default_nettype none

module pwmsd_load (
    input wire logic [3:0] pin_in,
    input wire logic [3:0] oe_in,
    output logic [3:0] level_out
);
    // ==========================================================
    // Pin level
    // A released pin is pulled low, which keeps the switch off
    assign level_out = oe_in & pin_in;
endmodule

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the PWM shutdown and polarity block
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic [7:0] rd_data_out;
    logic [3:0] pwm_raw_in = 4'h0;
    logic period_start_in = 1'b0;
    logic cmp_one_in = 1'b0;
    logic cmp_two_in = 1'b0;
    logic ext_int_n_in = 1'b1;
    logic sync_tick_in = 1'b0;
    logic [3:0] pwm_pin_out;
    logic [3:0] pwm_pin_oe_out;
    logic irq_out;
    logic [3:0] level;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [3:0] md = 4'h0;
    int err_count = 0;
    int comparisons = 0;
    int seed = 69;

    pwmsd_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .pwm_raw_in(pwm_raw_in),
        .period_start_in(period_start_in), .cmp_one_in(cmp_one_in),
        .cmp_two_in(cmp_two_in), .ext_int_n_in(ext_int_n_in),
        .sync_tick_in(sync_tick_in), .pwm_pin_out(pwm_pin_out),
        .pwm_pin_oe_out(pwm_pin_oe_out), .irq_out(irq_out));
    pwmsd_load i_load (.pin_in(pwm_pin_out), .oe_in(pwm_pin_oe_out), .level_out(level));

    // ==========================================================
    // Clock and watchdog
    always #2 clk_in = ~clk_in;

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        results();
    end

    // ==========================================================
    // Helpers
    task automatic results();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] fexp(input logic [1:0] ac, input logic [1:0] bd);
        logic [3:0] oe;
        oe = {~bd[1], ~ac[1], ~bd[1], ~ac[1]};
        return {oe, oe & {bd[0], ac[0], bd[0], ac[0]}};
    endfunction

    function automatic logic [7:0] nexp(input logic [3:0] raw, input logic [3:0] m);
        return {4'hf, raw ^ {m[0], m[1], m[0], m[1]}};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        exp_q.push_back(e);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
    endtask

    task automatic pulse(input logic tick);
        @(posedge clk_in);
        sync_tick_in <= tick;
        period_start_in <= !tick;
        @(posedge clk_in);
        sync_tick_in <= 1'b0;
        period_start_in <= 1'b0;
    endtask

    task automatic trig(input int t, input logic on);
        @(posedge clk_in);
        cmp_one_in <= on && t == 0;
        cmp_two_in <= on && t == 1;
        ext_int_n_in <= !(on && t == 2);
    endtask

    task automatic wait_irq();
        int i;
        for (i = 0; i < 10 && irq_out !== 1'b1; i++) begin
            @(posedge clk_in);
        end
        check({7'h0, irq_out}, 8'h01);
        if (irq_out !== 1'b1) begin
            results();
        end
    endtask

    // ==========================================================
    // Read data monitor
    always @(posedge clk_in) begin
        if (rd_pend) begin
            check(rd_data_out, exp_q.pop_front());
        end
        rd_pend <= rd_en_in;
    end

    // ==========================================================
    // Stimulus
    initial begin
        int s;
        int t;
        logic act;
        logic [1:0] ac;
        logic [1:0] bd;
        logic [7:0] sd;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 check({pwm_pin_oe_out, level}, 8'h00);
        rd(pwmsd_pkg::ADDR_SDCTL, pwmsd_pkg::SDCTL_RST);
        rd(8'h18, 8'h00);
        wr(pwmsd_pkg::ADDR_MODCTL, 8'h82);
        pulse(1'b0);
        rd(pwmsd_pkg::ADDR_IRQ_STAT, 8'h00);
        pulse(1'b0);
        rd(pwmsd_pkg::ADDR_IRQ_STAT, 8'h01);
        #1 check({pwm_pin_oe_out, level}, 8'h00);
        wr(pwmsd_pkg::ADDR_IRQ_MASK, 8'h02);
        rd(pwmsd_pkg::ADDR_IRQ_MASK, 8'h02);
        for (s = 0; s < 8; s++) begin
            md = {2'b00, s[1:0]};
            wr(pwmsd_pkg::ADDR_DRIVE, 8'h00);
            wr(pwmsd_pkg::ADDR_MODCTL, {4'h8, md});
            wr(pwmsd_pkg::ADDR_DRIVE, 8'h0f);
            pwm_raw_in <= 4'($random(seed));
            repeat (2) @(posedge clk_in);
            #1 check({pwm_pin_oe_out, level}, nexp(pwm_raw_in, md));
        end
        wr(pwmsd_pkg::ADDR_SDCTL, 8'h85);
        #1 check({pwm_pin_oe_out, level}, fexp(2'b01, 2'b01));
        rd(pwmsd_pkg::ADDR_SDCTL, 8'h85);
        wait_irq();
        wr(pwmsd_pkg::ADDR_SDCTL, 8'h05);
        pulse(1'b0);
        repeat (2) @(posedge clk_in);
        #1 check({pwm_pin_oe_out, level}, nexp(pwm_raw_in, md));
        wr(pwmsd_pkg::ADDR_IRQ_STAT, 8'h03);
        for (s = 0; s < 8; s++) begin
            for (t = 0; t < 3; t++) begin
                ac = s[1:0] + t[1:0];
                bd = s[1:0] ^ t[1:0];
                act = s[t];
                sd = {1'b0, s[2:0], ac, bd};
                wr(pwmsd_pkg::ADDR_SDCTL, sd);
                trig(t, 1'b1);
                #1 check({pwm_pin_oe_out, level}, act ? fexp(ac, bd) : nexp(pwm_raw_in, md));
                repeat (4) @(posedge clk_in);
                rd(pwmsd_pkg::ADDR_SDCTL, sd | {act, 7'h00});
                wr(pwmsd_pkg::ADDR_SDCTL, sd);
                rd(pwmsd_pkg::ADDR_SDCTL, sd | {act, 7'h00});
                if (act) begin
                    wait_irq();
                end else begin
                    check({7'h0, irq_out}, 8'h00);
                end
                trig(t, 1'b0);
                repeat (4) @(posedge clk_in);
                rd(pwmsd_pkg::ADDR_SDCTL, sd | {act, 7'h00});
                wr(pwmsd_pkg::ADDR_SDCTL, sd);
                #1 check({pwm_pin_oe_out, level}, act ? fexp(ac, bd) : nexp(pwm_raw_in, md));
                pulse(1'b0);
                repeat (2) @(posedge clk_in);
                #1 check({pwm_pin_oe_out, level}, nexp(pwm_raw_in, md));
                wr(pwmsd_pkg::ADDR_IRQ_STAT, 8'h03);
            end
        end
        wr(pwmsd_pkg::ADDR_CFG, 8'h80);
        rd(pwmsd_pkg::ADDR_CFG, 8'h80);
        wr(pwmsd_pkg::ADDR_SDCTL, 8'h10);
        trig(0, 1'b1);
        repeat (5) @(posedge clk_in);
        rd(pwmsd_pkg::ADDR_SDCTL, 8'h90);
        trig(0, 1'b0);
        repeat (5) @(posedge clk_in);
        rd(pwmsd_pkg::ADDR_SDCTL, 8'h10);
        wr(pwmsd_pkg::ADDR_CFG, 8'h81);
        wr(pwmsd_pkg::ADDR_SDCTL, 8'h20);
        pulse(1'b0);
        trig(1, 1'b1);
        repeat (3) @(posedge clk_in);
        #1 check({pwm_pin_oe_out, level}, nexp(pwm_raw_in, md));
        pulse(1'b1);
        #1 check({pwm_pin_oe_out, level}, fexp(2'b00, 2'b00));
        trig(1, 1'b0);
        repeat (3) @(posedge clk_in);
        pulse(1'b1);
        repeat (3) @(posedge clk_in);
        pulse(1'b0);
        repeat (2) @(posedge clk_in);
        #1 check({pwm_pin_oe_out, level}, nexp(pwm_raw_in, md));
        repeat (3) @(posedge clk_in);
        results();
    end
endmodule

`default_nettype wire
